/* logic/hbfs_device.sv */
// Fault supervisor of the twelve-channel half-bridge driver
`timescale 1ns/1ns
`include "hbfs_regs.svh"
module hbfs_device (
    // System
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial link
    hbfs_link_if.device      link,
    // Comparators and pins
    input  wire logic        load_supply_uv,
    input  wire logic        temp_warn_set,
    input  wire logic        temp_warn_reset,
    input  wire logic        temp_shutdown,
    input  wire logic        temp_switch_on,
    input  wire logic [11:0] overcurrent,
    input  wire logic [11:0] open_load_sense,
    input  wire logic        hardware_standby_pin,
    input  wire logic        osc_clk,
    // Output stage controls
    output logic      [11:0] switch_on_q,
    output logic      [11:0] test_current_q,
    output logic      [11:0] current_limit_q
);

    localparam int CH       = `HBFS_CHANNELS;
    localparam int SC_LONG  = (`HBFS_SC_LONG_US * 1000) / `HBFS_OSC_NS;
    localparam int SC_SHORT = (`HBFS_SC_SHORT_US * 1000) / `HBFS_OSC_NS;
    localparam int UV_TICKS = (`HBFS_UV_DELAY_US * 1000) / `HBFS_OSC_NS;

    // Two-stage synchronisers for every outside input
    logic [33:0] async_in;
    logic [33:0] meta_q;
    logic [33:0] sync_q;

    assign async_in = {osc_clk, link.cs_n, link.sclk, link.sdi, load_supply_uv,
                       temp_warn_set, temp_warn_reset, temp_shutdown, temp_switch_on,
                       hardware_standby_pin, overcurrent, open_load_sense};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= `HBFS_SYNC_RESET;
            sync_q <= `HBFS_SYNC_RESET;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    logic        osc_s;
    logic        cs_n_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        uv_s;
    logic        tws_s;
    logic        twr_s;
    logic        tsd_s;
    logic        tson_s;
    logic        stby_s;
    logic [11:0] oc_s;
    logic [11:0] ol_s;

    assign osc_s  = sync_q[33];
    assign cs_n_s = sync_q[32];
    assign sclk_s = sync_q[31];
    assign sdi_s  = sync_q[30];
    assign uv_s   = sync_q[29];
    assign tws_s  = sync_q[28];
    assign twr_s  = sync_q[27];
    assign tsd_s  = sync_q[26];
    assign tson_s = sync_q[25];
    assign stby_s = sync_q[24];
    assign oc_s   = sync_q[23:12];
    assign ol_s   = sync_q[11:0];

    // Edge detection on synchronised levels
    logic [2:0] prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= `HBFS_EDGE_RESET;
        end else begin
            prev_q <= {osc_s, cs_n_s, sclk_s};
        end
    end

    logic tick;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    assign tick      = osc_s & ~prev_q[2];
    assign cs_fall   = ~cs_n_s & prev_q[1];
    assign cs_rise   = cs_n_s & ~prev_q[1];
    assign sclk_rise = ~cs_n_s & sclk_s & ~prev_q[0];
    assign sclk_fall = ~cs_n_s & ~sclk_s & prev_q[0];

    // Input word and status flags
    hbfs_pkg::hbfs_word_t in_q;
    hbfs_pkg::hbfs_word_t rx_sh_q;
    hbfs_pkg::hbfs_word_t tx_sh_q;
    hbfs_pkg::hbfs_word_t out_word;
    logic [4:0]           bit_cnt_q;
    logic                 sdo_q;
    logic                 clear_q;
    logic                 psf_q;
    logic                 uv_off_q;
    logic [9:0]           uv_cnt_q;
    logic                 tw_q;
    logic                 tsd_q;
    logic                 clr_pend_q;
    logic                 scd_q;
    logic [CH-1:0]        sc_off_q;
    logic [CH-1:0]        sc_trip;
    logic [CH-1:0]        status;
    logic [CH-1:0]        cmd;
    logic                 inhibit;
    logic                 enable;

    assign cmd     = in_q[CH:1];
    assign inhibit = ~in_q[`HBFS_IN_SOFT_RUN] | ~stby_s;
    assign enable  = ~uv_off_q & ~tsd_q & ~inhibit;

    // Serial shift engine, LSB first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_q      <= `HBFS_IN_RESET;
            rx_sh_q   <= '0;
            tx_sh_q   <= '0;
            bit_cnt_q <= '0;
            sdo_q     <= 1'b0;
            clear_q   <= 1'b0;
        end else begin
            clear_q <= 1'b0;
            if (cs_fall) begin
                tx_sh_q   <= out_word;
                sdo_q     <= out_word[`HBFS_OUT_WARN];
                bit_cnt_q <= '0;
            end else if (cs_rise) begin
                // Incomplete word aborts with no change
                if (bit_cnt_q == 5'h10) begin
                    in_q    <= rx_sh_q;
                    clear_q <= rx_sh_q[`HBFS_IN_CLEAR];
                end
            end else begin
                if (sclk_rise) begin
                    rx_sh_q <= {sdi_s, rx_sh_q[15:1]};
                    if (bit_cnt_q != 5'h10) begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                if (sclk_fall) begin
                    tx_sh_q <= {1'b0, tx_sh_q[15:1]};
                    sdo_q   <= tx_sh_q[1];
                end
            end
        end
    end

    assign link.sdo = sdo_q;

    // Undervoltage delay and supply-fail flag
    always_ff @(posedge clk) begin
        if (sys_rst || !uv_s) begin
            uv_cnt_q <= '0;
            uv_off_q <= 1'b0;
        end else if (tick && !uv_off_q) begin
            if (uv_cnt_q >= 10'(UV_TICKS - 1)) begin
                uv_off_q <= 1'b1;
            end else begin
                uv_cnt_q <= uv_cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psf_q <= 1'b0;
        end else if (uv_off_q) begin
            psf_q <= 1'b1;
        end else if (clear_q) begin
            psf_q <= 1'b0;
        end
    end

    // Thermal warning with hysteresis
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tw_q <= 1'b0;
        end else if (tws_s) begin
            tw_q <= 1'b1;
        end else if (twr_s) begin
            tw_q <= 1'b0;
        end
    end

    // Thermal shutdown, released by clear once cool
    always_ff @(posedge clk) begin
        if (sys_rst || !tsd_q) begin
            clr_pend_q <= 1'b0;
        end else if (clear_q) begin
            clr_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tsd_q <= 1'b0;
        end else if (tsd_s) begin
            tsd_q <= 1'b1;
        end else if ((clr_pend_q || clear_q) && tson_s) begin
            tsd_q <= 1'b0;
        end
    end

    // Per-channel short-circuit timers
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_short
            logic [9:0] cnt_q;
            logic       active;
            logic [9:0] limit;

            assign active = oc_s[gi] & switch_on_q[gi];
            assign limit  = in_q[`HBFS_IN_DELAY_SEL] ? 10'(SC_LONG - 1)
                                                     : 10'(SC_SHORT - 1);
            assign sc_trip[gi] = active & (tw_q | (tick & (cnt_q >= limit)));

            always_ff @(posedge clk) begin
                if (sys_rst || !active) begin
                    cnt_q <= '0;
                end else if (tick && cnt_q < limit) begin
                    cnt_q <= cnt_q + 10'h001;
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sc_off_q[gi] <= 1'b0;
                end else if (sc_trip[gi]) begin
                    sc_off_q[gi] <= 1'b1;
                end else if (clear_q) begin
                    sc_off_q[gi] <= 1'b0;
                end
            end

            assign status[gi] = test_current_q[gi] ? ol_s[gi] : switch_on_q[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scd_q <= 1'b0;
        end else if (|sc_trip) begin
            scd_q <= 1'b1;
        end else if (clear_q) begin
            scd_q <= 1'b0;
        end
    end

    // Output stage gating
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            switch_on_q     <= '0;
            test_current_q  <= '0;
            current_limit_q <= '0;
        end else begin
            switch_on_q     <= cmd & ~sc_off_q & {CH{enable}};
            test_current_q  <= ~cmd & {CH{~in_q[`HBFS_IN_OL_EN_N]}};
            current_limit_q <= oc_s & switch_on_q;
        end
    end

    // Status word snapshot
    always_comb begin
        if (tsd_q) begin
            out_word = '1;
        end else begin
            out_word = {psf_q, inhibit, scd_q, status, tw_q};
        end
    end

endmodule

/* logic/hbfs_regs.svh */
// Constants of the half-bridge fault supervisor and its host controller
// Operation
// - Persistent undervoltage sets supply fail, disables outputs
// - Supply recovery re-enables outputs without delay
// - Supply fail latched until fault clear written
// - Open-load enable low turns test currents on
// - Open load below threshold sets status bit
// - Switched-on output suspends its open-load detection
// - Thermal warning flag with set/reset hysteresis
// - Chip select fall presents thermal warning
// - Short chip select leaves both words unchanged
// - Thermal shutdown disables outputs, word all ones
// - Restart needs cool temperature and fault clear
// - Overcurrent limits current and starts short timer
// - Persistent short disables output, sets short flag
// - Warning during short trips output at once
// - Fault clear resets short flag, re-enables outputs
// - Soft inhibit or standby pin stops outputs
// - Outputs need soft inhibit one, pin high
// - Delay select high long, low short
// - Fault clear at bit 0 clears flags
// - Status word bits 0, 13, 14, 15
`ifndef HBFS_REGS_SVH
`define HBFS_REGS_SVH

`define HBFS_WORD_BITS    16
`define HBFS_CHANNELS     12

// Input word fields and reset value
`define HBFS_IN_RESET     16'he000
`define HBFS_IN_CLEAR     0
`define HBFS_IN_OL_EN_N   13
`define HBFS_IN_DELAY_SEL 14
`define HBFS_IN_SOFT_RUN  15

// Output word fields
`define HBFS_OUT_WARN     0
`define HBFS_OUT_SHORT    13
`define HBFS_OUT_INHIBIT  14
`define HBFS_OUT_SUPPLY   15

// Synchroniser and edge detector reset levels, select idles high
`define HBFS_SYNC_RESET   34'h1_0000_0000
`define HBFS_EDGE_RESET   3'h2

// Timing
`define HBFS_CLK_NS       40
`define HBFS_SCLK_NS      320
`define HBFS_OSC_NS       31250
`define HBFS_SC_LONG_US   12000
`define HBFS_SC_SHORT_US  1500
`define HBFS_UV_DELAY_US  1000
`define HBFS_PEEK_CYCLES  8
`define HBFS_CS_HOLD      7
`define HBFS_CS_GAP       15

// Host register offsets
`define HBFS_OFS_CTRL     32'h0000_0000
`define HBFS_OFS_TX       32'h0000_0004
`define HBFS_OFS_RX       32'h0000_0008
`define HBFS_OFS_STATUS   32'h0000_000c

`endif

/* logic/hbfs_pkg.sv */
// Types of the fault supervisor link; the word type serves both ends, the state and select types the host
package hbfs_pkg;

    typedef logic [15:0] hbfs_word_t;

    typedef enum logic [1:0] {
        HBFS_IDLE,
        HBFS_SHIFT,
        HBFS_PEEK,
        HBFS_TAIL
    } hbfs_host_state_t;

    typedef enum logic [2:0] {
        HBFS_SEL_CTRL,
        HBFS_SEL_TX,
        HBFS_SEL_RX,
        HBFS_SEL_STATUS,
        HBFS_SEL_NONE
    } hbfs_reg_sel_t;

endpackage

/* logic/hbfs_link_if.sv */
// Serial link between the host controller and the supervisor
`timescale 1ns/1ns
interface hbfs_link_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;

    modport device (
        input  cs_n,
        input  sclk,
        input  sdi,
        output sdo
    );

    modport host (
        output cs_n,
        output sclk,
        output sdi,
        input  sdo
    );
endinterface

/* logic/hbfs_host.sv */
// Host controller: APB registers driving the serial link
`timescale 1ns/1ns
`include "hbfs_regs.svh"
module hbfs_host (
    // System
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    // Serial link
    hbfs_link_if.host        link
);

    localparam int HALF = `HBFS_SCLK_NS / (2 * `HBFS_CLK_NS);

    function automatic hbfs_pkg::hbfs_reg_sel_t reg_sel(input logic [31:0] addr);
        case (addr)
            `HBFS_OFS_CTRL:   reg_sel = hbfs_pkg::HBFS_SEL_CTRL;
            `HBFS_OFS_TX:     reg_sel = hbfs_pkg::HBFS_SEL_TX;
            `HBFS_OFS_RX:     reg_sel = hbfs_pkg::HBFS_SEL_RX;
            `HBFS_OFS_STATUS: reg_sel = hbfs_pkg::HBFS_SEL_STATUS;
            default:          reg_sel = hbfs_pkg::HBFS_SEL_NONE;
        endcase
    endfunction

    hbfs_pkg::hbfs_host_state_t state_q;
    hbfs_pkg::hbfs_word_t       tx_q;
    hbfs_pkg::hbfs_word_t       rx_q;
    hbfs_pkg::hbfs_word_t       tsh_q;
    hbfs_pkg::hbfs_word_t       rsh_q;
    logic [3:0]                 cnt_q;
    logic [3:0]                 bit_q;
    logic                       warn_q;
    logic                       cs_n_q;
    logic                       sclk_q;
    logic                       sdi_q;
    logic                       sdo_m_q;
    logic                       sdo_s_q;
    logic                       acc_wr;
    logic                       busy;
    logic                       go_full;
    logic                       go_peek;

    assign busy    = state_q != hbfs_pkg::HBFS_IDLE;
    assign acc_wr  = psel & penable & pready_q & pwrite;
    assign go_full = acc_wr & (reg_sel(paddr) == hbfs_pkg::HBFS_SEL_CTRL) & pwdata[0];
    assign go_peek = acc_wr & (reg_sel(paddr) == hbfs_pkg::HBFS_SEL_CTRL) & pwdata[1];

    // APB answer, one access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (psel && !penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= reg_sel(paddr) == hbfs_pkg::HBFS_SEL_NONE;
            case (reg_sel(paddr))
                hbfs_pkg::HBFS_SEL_TX:     prdata_q <= {16'h0000, tx_q};
                hbfs_pkg::HBFS_SEL_RX:     prdata_q <= {16'h0000, rx_q};
                hbfs_pkg::HBFS_SEL_STATUS: prdata_q <= {30'h0, warn_q, busy};
                default:                   prdata_q <= '0;
            endcase
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_q <= '0;
        end else if (acc_wr && reg_sel(paddr) == hbfs_pkg::HBFS_SEL_TX) begin
            tx_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdo_m_q <= 1'b0;
            sdo_s_q <= 1'b0;
        end else begin
            sdo_m_q <= link.sdo;
            sdo_s_q <= sdo_m_q;
        end
    end

    // Link sequencer; clock divided from clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= hbfs_pkg::HBFS_IDLE;
            cs_n_q  <= 1'b1;
            sclk_q  <= 1'b0;
            sdi_q   <= 1'b0;
            cnt_q   <= '0;
            bit_q   <= '0;
            tsh_q   <= '0;
            rsh_q   <= '0;
            rx_q    <= '0;
            warn_q  <= 1'b0;
        end else begin
            case (state_q)
                hbfs_pkg::HBFS_IDLE: begin
                    cnt_q <= '0;
                    bit_q <= '0;
                    if (go_full) begin
                        cs_n_q  <= 1'b0;
                        tsh_q   <= tx_q;
                        sdi_q   <= tx_q[0];
                        state_q <= hbfs_pkg::HBFS_SHIFT;
                    end else if (go_peek) begin
                        cs_n_q  <= 1'b0;
                        state_q <= hbfs_pkg::HBFS_PEEK;
                    end
                end
                hbfs_pkg::HBFS_SHIFT: begin
                    if (cnt_q == 4'(HALF - 1)) begin
                        cnt_q  <= '0;
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            rsh_q <= {sdo_s_q, rsh_q[15:1]};
                            if (bit_q == 4'hf) begin
                                rx_q    <= {sdo_s_q, rsh_q[15:1]};
                                state_q <= hbfs_pkg::HBFS_TAIL;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                tsh_q <= {1'b0, tsh_q[15:1]};
                                sdi_q <= tsh_q[1];
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                hbfs_pkg::HBFS_PEEK: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(`HBFS_PEEK_CYCLES - 1)) begin
                        warn_q  <= sdo_s_q;
                        cnt_q   <= '0;
                        state_q <= hbfs_pkg::HBFS_TAIL;
                    end
                end
                hbfs_pkg::HBFS_TAIL: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(`HBFS_CS_HOLD)) begin
                        cs_n_q <= 1'b1;
                    end
                    if (cnt_q == 4'(`HBFS_CS_GAP)) begin
                        state_q <= hbfs_pkg::HBFS_IDLE;
                    end
                end
                default: state_q <= hbfs_pkg::HBFS_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.sdi  = sdi_q;

endmodule

/* test/hbfs_link_chk.sv */
// Wire-level checks of the supervisor serial link
`timescale 1ns/1ns
module hbfs_link_chk (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock runs while deselected");
    a_cs_fall_quiet: assert property ($fell(cs_n) |-> (!cs_n && !sclk)[*4])
        else $error("serial clock too soon after select");
    a_sclk_high_len: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    a_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("serial clock low phase too short");
    a_sdo_steady: assert property (sclk && $past(sclk) |-> $stable(sdo))
        else $error("device data moved while clock high");
    a_sdi_steady: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("host data moved while clock high");
    a_cs_gap_len: assert property ($rose(cs_n) |-> cs_n[*8])
        else $error("deselect gap too short");
    a_cs_rise_tail: assert property ($rose(cs_n) |-> !$past(sclk, 4))
        else $error("deselect too close to last clock");

    // Main traffic kinds
    c_full_word: cover property ($rose(sclk));
    c_peek_only: cover property ($fell(cs_n) ##1 (!sclk)[*8] ##[1:20] $rose(cs_n));
    c_back_to_back: cover property ($rose(cs_n) ##[8:40] $fell(cs_n));
endmodule

/* test/testbench.sv */
// Self-checking bench joining host controller and supervisor
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        perr;
    logic        load_supply_uv = 1'b0;
    logic        temp_warn_set = 1'b0;
    logic        temp_warn_reset = 1'b1;
    logic        temp_shutdown = 1'b0;
    logic        temp_switch_on = 1'b1;
    logic [11:0] overcurrent = 12'h000;
    logic [11:0] open_load_sense = 12'h000;
    logic        hardware_standby_pin = 1'b1;
    logic        osc_clk = 1'b0;
    logic [11:0] switch_on_q;
    logic [11:0] test_current_q;
    logic [11:0] current_limit_q;
    logic [31:0] d;
    logic [15:0] r;
    int          n_mismatch = 0;
    int          compares = 0;

    hbfs_link_if hbfs_link_if_inst ();

    hbfs_host hbfs_host_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .link(hbfs_link_if_inst));

    hbfs_device hbfs_device_inst (.clk(clk), .sys_rst(sys_rst), .link(hbfs_link_if_inst),
        .load_supply_uv(load_supply_uv), .temp_warn_set(temp_warn_set),
        .temp_warn_reset(temp_warn_reset), .temp_shutdown(temp_shutdown),
        .temp_switch_on(temp_switch_on), .overcurrent(overcurrent),
        .open_load_sense(open_load_sense), .hardware_standby_pin(hardware_standby_pin),
        .osc_clk(osc_clk), .switch_on_q(switch_on_q), .test_current_q(test_current_q),
        .current_limit_q(current_limit_q));

    hbfs_link_chk hbfs_link_chk_inst (.clk(clk), .sys_rst(sys_rst),
        .cs_n(hbfs_link_if_inst.cs_n), .sclk(hbfs_link_if_inst.sclk),
        .sdi(hbfs_link_if_inst.sdi), .sdo(hbfs_link_if_inst.sdo));

    initial forever #20 clk = ~clk;
    // Slow time base sped up to ten system clocks a tick
    initial forever begin
        repeat (5) @(posedge clk);
        osc_clk <= ~osc_clk;
    end

    task automatic close_out();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Wait for the answer; only the watchdog ends a hang
        while (pready_q !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata_q;
        perr = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Sends w (cmd 1) or peeks (cmd 2); returns received word or status
    task automatic xfer(input logic [15:0] w, input logic [31:0] cmd,
                        output logic [15:0] rw);
        logic [31:0] s;
        int          n;
        n = 0;
        apb(1'b1, 32'h4, {16'h0, w}, s);
        apb(1'b1, 32'h0, cmd, s);
        do begin
            apb(1'b0, 32'hc, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 200);
        if (n == 200)
            n_mismatch++;
        if (cmd[0])
            apb(1'b0, 32'h8, 32'h0, s);
        rw = s[15:0];
    endtask

    task automatic sw_chk(input int c, input logic [11:0] e);
        repeat (c) @(posedge clk);
        cmp({4'h0, switch_on_q}, {4'h0, e});
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, 32'h10, 32'h0, d);
        cmp({perr, d[14:0]}, 16'h8000);
        apb(1'b1, 32'h4, 32'h1234, d);
        apb(1'b0, 32'h4, 32'h0, d);
        cmp(d[15:0], 16'h1234);
        // Inhibit by pin and by soft bit
        xfer(16'ha006, 32'h1, r);
        sw_chk(4, 12'h003);
        hardware_standby_pin <= 1'b0;
        sw_chk(6, 12'h000);
        xfer(16'ha006, 32'h1, r);
        cmp(r & 16'he001, 16'h4000);
        hardware_standby_pin <= 1'b1;
        sw_chk(6, 12'h003);
        xfer(16'h2006, 32'h1, r);
        sw_chk(4, 12'h000);
        // Warning peek with hysteresis, words untouched
        xfer(16'ha006, 32'h1, r);
        temp_warn_set <= 1'b1;
        temp_warn_reset <= 1'b0;
        sw_chk(8, 12'h003);
        xfer(16'h0000, 32'h2, r);
        cmp(r & 16'h0002, 16'h0002);
        sw_chk(4, 12'h003);
        temp_warn_set <= 1'b0;
        xfer(16'h0000, 32'h2, r);
        cmp(r & 16'h0002, 16'h0002);
        temp_warn_reset <= 1'b1;
        sw_chk(8, 12'h003);
        xfer(16'h0000, 32'h2, r);
        cmp(r & 16'h0002, 16'h0000);
        // Undervoltage
        load_supply_uv <= 1'b1;
        sw_chk(250, 12'h003);
        sw_chk(150, 12'h000);
        load_supply_uv <= 1'b0;
        sw_chk(6, 12'h003);
        xfer(16'ha006, 32'h1, r);
        cmp(r & 16'h8000, 16'h8000);
        xfer(16'ha007, 32'h1, r);
        xfer(16'ha006, 32'h1, r);
        cmp(r & 16'h8000, 16'h0000);
        load_supply_uv <= 1'b1;
        sw_chk(250, 12'h003);
        load_supply_uv <= 1'b0;
        sw_chk(4, 12'h003);
        load_supply_uv <= 1'b1;
        sw_chk(250, 12'h003);
        load_supply_uv <= 1'b0;
        // Short circuit, short and long delay
        overcurrent <= 12'h001;
        repeat (6) @(posedge clk);
        cmp({4'h0, current_limit_q}, 16'h0001);
        sw_chk(400, 12'h003);
        sw_chk(150, 12'h002);
        xfer(16'ha006, 32'h1, r);
        cmp(r & 16'h2000, 16'h2000);
        overcurrent <= 12'h000;
        xfer(16'ha007, 32'h1, r);
        sw_chk(4, 12'h003);
        xfer(16'he006, 32'h1, r);
        overcurrent <= 12'h002;
        sw_chk(3700, 12'h003);
        sw_chk(300, 12'h001);
        overcurrent <= 12'h000;
        xfer(16'ha007, 32'h1, r);
        overcurrent <= 12'h001;
        sw_chk(50, 12'h003);
        temp_warn_set <= 1'b1;
        sw_chk(8, 12'h002);
        overcurrent <= 12'h000;
        temp_warn_set <= 1'b0;
        // Thermal shutdown and restart
        xfer(16'ha007, 32'h1, r);
        temp_shutdown <= 1'b1;
        temp_switch_on <= 1'b0;
        sw_chk(6, 12'h000);
        xfer(16'ha006, 32'h1, r);
        cmp(r, 16'hffff);
        temp_shutdown <= 1'b0;
        xfer(16'ha007, 32'h1, r);
        sw_chk(4, 12'h000);
        temp_switch_on <= 1'b1;
        sw_chk(6, 12'h003);
        // Open load
        xfer(16'h8006, 32'h1, r);
        open_load_sense <= 12'h005;
        sw_chk(4, 12'h003);
        cmp({4'h0, test_current_q}, 16'h0ffc);
        xfer(16'h8006, 32'h1, r);
        cmp(r, 16'h000e);
        close_out();
    end
endmodule
